// [hdl/pct_color_xform.sv]
`timescale 1ns/10ps
//
// Overview of operation
// - pixel out equals 3x3 gains times input plus offsets
// - two matrix instances: colour correction and luma-chroma
// - correction maps native sensor rgb to standard rgb
// - correction on flag: 0 bypasses, 1 applies
// - illuminant preset picks calibrated correction matrix
// - custom preset uses user-written gains and offsets
// - luma-chroma conversion sits after correction and gamma
// - luma-chroma active exactly when output format is yuv, the pipe is enabled and the variant is not polarized
// - coefficient read returns value in use by instance
// - vividness adjust only while its enable is one
// - polarized variants have no transform stage
// - index selects nine gains and three offsets
// - instance selector steers later on and coefficient access
// - on flag read-only when luma-chroma instance selected
// - preset choice other than custom also loads red and blue balance
//
module pct_color_xform #(
  parameter bit POLARIZED = 1'b0,
  parameter logic [pct_pkg::N_PRESET-1:0][pct_pkg::N_COEF-1:0][pct_pkg::COEF_W-1:0] PRESET_COEFS =
    {pct_pkg::N_PRESET{pct_pkg::IDENT_COEFS}}
) (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  // register port
  input wire logic [pct_pkg::ADDR_W-1:0] i_addr,
  input wire logic [pct_pkg::DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [pct_pkg::DATA_W-1:0] o_rdata,
  // frame boundary strobe, between frames
  input wire logic i_frame_sync,
  // native rgb pixels from demosaic
  input wire logic i_pix_valid,
  input wire logic [pct_pkg::PIX_W-1:0] i_pix_r,
  input wire logic [pct_pkg::PIX_W-1:0] i_pix_g,
  input wire logic [pct_pkg::PIX_W-1:0] i_pix_b,
  // corrected rgb to gamma
  output logic o_gamma_valid,
  output logic [pct_pkg::PIX_W-1:0] o_gamma_r,
  output logic [pct_pkg::PIX_W-1:0] o_gamma_g,
  output logic [pct_pkg::PIX_W-1:0] o_gamma_b,
  // gamma-corrected rgb back in
  input wire logic i_gamma_valid,
  input wire logic [pct_pkg::PIX_W-1:0] i_gamma_r,
  input wire logic [pct_pkg::PIX_W-1:0] i_gamma_g,
  input wire logic [pct_pkg::PIX_W-1:0] i_gamma_b,
  // final pixels to the output formatter
  output logic o_pix_valid,
  output logic [pct_pkg::PIX_W-1:0] o_pix_c0,
  output logic [pct_pkg::PIX_W-1:0] o_pix_c1,
  output logic [pct_pkg::PIX_W-1:0] o_pix_c2,
  // white balance ratios for the balance stage
  output logic [pct_pkg::COEF_W-1:0] o_wb_red,
  output logic [pct_pkg::COEF_W-1:0] o_wb_blue
);
  import pct_pkg::*;
  localparam bit HAS_XFORM = !POLARIZED;

  // ---------------------------------------------------------------
  // software-visible state
  // ---------------------------------------------------------------
  logic [2:0] ctrl_q;
  pct_inst_type inst_sel_q;
  logic rgb_on_q;
  logic [3:0] coef_idx_q;
  pct_illum_type illum_q;
  logic [SAT_W-1:0] sat_q;
  logic [COEF_W-1:0] wb_red_q;
  logic [COEF_W-1:0] wb_blue_q;
  pct_coef_type cust_q;
  logic [DATA_W-1:0] rdata_q;

  // ---------------------------------------------------------------
  // settings in force for the current frame
  // ---------------------------------------------------------------
  pct_coef_type act_rgb_q;
  logic act_rgb_on_q;
  logic act_yuv_q;
  logic act_sat_q;
  logic [SAT_W-1:0] act_sat_val_q;
  logic pend_q;
  logic pend_d;

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  wire pipe_en_w = ctrl_q[CTRL_PIPE_EN_BIT];
  wire xf_ok_w = pipe_en_w && HAS_XFORM;
  wire sel_rgb_w = (inst_sel_q == INST_NATIVE_TO_STANDARD_RGB);
  wire custom_w = (illum_q == ILLUM_CUSTOM);
  wire wr_ctrl_w = i_wr && (i_addr == REG_CTRL);
  wire wr_sel_w = i_wr && xf_ok_w && (i_addr == REG_INST_SEL);
  wire wr_on_w = i_wr && xf_ok_w && (i_addr == REG_INST_ON) && sel_rgb_w;
  wire wr_idx_w = i_wr && xf_ok_w && (i_addr == REG_COEF_SEL);
  wire wr_coef_w = i_wr && xf_ok_w && (i_addr == REG_COEF_VAL) && sel_rgb_w && custom_w
    && (coef_idx_q < 4'(N_COEF));
  wire wr_illum_w = i_wr && xf_ok_w && (i_addr == REG_ILLUM);
  wire wr_sat_w = i_wr && xf_ok_w && (i_addr == REG_SAT);
  wire wr_wbr_w = i_wr && xf_ok_w && (i_addr == REG_WB_RED);
  wire wr_wbb_w = i_wr && xf_ok_w && (i_addr == REG_WB_BLUE);
  wire pct_illum_type new_illum_w = pct_illum_type'(i_wdata[2:0]);
  wire load_wb_w = wr_illum_w && (new_illum_w != ILLUM_CUSTOM);
  wire pct_coef_type preset_w = PRESET_COEFS[illum_q[2:0]];
  wire cfg_wr_w = wr_ctrl_w || wr_on_w || wr_coef_w || wr_illum_w || wr_sat_w;

  // ---------------------------------------------------------------
  // read selection
  // ---------------------------------------------------------------
  // readback shows the frame's active coefficients, not a pending custom write
  wire [COEF_W-1:0] coef_rd_w = sel_rgb_w ? coef_at(act_rgb_q, coef_idx_q)
    : coef_at(YUV_COEFS, coef_idx_q);
  wire on_rd_w = sel_rgb_w ? rgb_on_q : ctrl_q[CTRL_YUV_FMT_BIT];
  wire [4:0] status_w = {HAS_XFORM, act_sat_q, act_yuv_q, act_rgb_on_q, pend_q};
  wire [DATA_W-1:0] rd_w =
    (i_addr == REG_CTRL) ? DATA_W'(ctrl_q) :
    (i_addr == REG_STATUS) ? DATA_W'(status_w) :
    !xf_ok_w ? '0 :
    (i_addr == REG_INST_SEL) ? DATA_W'(inst_sel_q) :
    (i_addr == REG_INST_ON) ? DATA_W'(on_rd_w) :
    (i_addr == REG_COEF_SEL) ? DATA_W'(coef_idx_q) :
    (i_addr == REG_COEF_VAL) ? DATA_W'(coef_rd_w) :
    (i_addr == REG_ILLUM) ? DATA_W'(illum_q) :
    (i_addr == REG_SAT) ? DATA_W'(sat_q) :
    (i_addr == REG_WB_RED) ? DATA_W'(wb_red_q) :
    (i_addr == REG_WB_BLUE) ? DATA_W'(wb_blue_q) : '0;

  // ---------------------------------------------------------------
  // control registers
  // ---------------------------------------------------------------
  // writes to the luma-chroma on flag fall through; only pixel format moves it
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ctrl_q <= CTRL_RESET;
      inst_sel_q <= INST_NATIVE_TO_STANDARD_RGB;
      rgb_on_q <= RGB_ON_RESET;
      coef_idx_q <= '0;
      illum_q <= ILLUM_GENERAL;
      sat_q <= SAT_RESET;
    end else begin
      if (wr_ctrl_w) ctrl_q <= i_wdata[2:0];
      if (wr_sel_w) inst_sel_q <= pct_inst_type'(i_wdata[0]);
      if (wr_on_w) rgb_on_q <= i_wdata[0];
      if (wr_idx_w) coef_idx_q <= i_wdata[3:0];
      if (wr_illum_w) illum_q <= new_illum_w;
      if (wr_sat_w) sat_q <= i_wdata[SAT_W-1:0];
    end
  end

  // balance ratios follow each preset but custom, software may overwrite them later
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      wb_red_q <= WB_RED_TAB[0];
      wb_blue_q <= WB_BLUE_TAB[0];
    end else begin
      if (load_wb_w) wb_red_q <= WB_RED_TAB[new_illum_w[2:0]];
      else if (wr_wbr_w) wb_red_q <= i_wdata[COEF_W-1:0];
      if (load_wb_w) wb_blue_q <= WB_BLUE_TAB[new_illum_w[2:0]];
      else if (wr_wbb_w) wb_blue_q <= i_wdata[COEF_W-1:0];
    end
  end

  // custom bank is a shadow; it reaches the datapath only at frame sync
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cust_q <= IDENT_COEFS;
    end else if (wr_coef_w) begin
      cust_q[coef_idx_q] <= i_wdata[COEF_W-1:0];
    end
  end

  // ---------------------------------------------------------------
  // frame boundary transfer
  // ---------------------------------------------------------------
  // a write in the sync cycle keeps pend set, so it is not lost
  assign pend_d = cfg_wr_w || (pend_q && !i_frame_sync);

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      act_rgb_q <= IDENT_COEFS;
      act_rgb_on_q <= 1'b0;
      act_yuv_q <= 1'b0;
      act_sat_q <= 1'b0;
      act_sat_val_q <= SAT_RESET;
      pend_q <= 1'b0;
    end else begin
      pend_q <= pend_d;
      if (i_frame_sync) begin
        act_rgb_q <= custom_w ? cust_q : preset_w;
        act_rgb_on_q <= xf_ok_w && rgb_on_q;
        act_yuv_q <= xf_ok_w && ctrl_q[CTRL_YUV_FMT_BIT];
        act_sat_q <= xf_ok_w && ctrl_q[CTRL_VIVID_BIT];
        act_sat_val_q <= sat_q;
      end
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) rdata_q <= '0;
    else rdata_q <= i_rd ? rd_w : '0;
  end
  assign o_rdata = rdata_q;
  assign o_wb_red = wb_red_q;
  assign o_wb_blue = wb_blue_q;

  // ---------------------------------------------------------------
  // datapath: correction, vividness, gamma loop, luma-chroma
  // ---------------------------------------------------------------
  pct_pix_if #(.PW(PIX_W)) px_in();
  pct_pix_if #(.PW(PIX_W)) px_corr();
  pct_pix_if #(.PW(PIX_W)) px_sat();
  pct_pix_if #(.PW(PIX_W)) px_gam();
  pct_pix_if #(.PW(PIX_W)) px_out();

  assign px_in.valid = i_pix_valid;
  assign px_in.ch = {i_pix_b, i_pix_g, i_pix_r};

  // native sensor rgb into the standard rgb space
  pct_matrix #(.PW(PIX_W), .CW(COEF_W)) u_native_to_standard_rgb (
    .i_sys_clk(i_sys_clk),
    .i_rstn(i_rstn),
    .i_apply(act_rgb_on_q),
    .i_coef(act_rgb_q),
    .in_px(px_in),
    .out_px(px_corr)
  );

  pct_saturate #(.PW(PIX_W)) u_vividness (
    .i_sys_clk(i_sys_clk),
    .i_rstn(i_rstn),
    .i_apply(act_sat_q),
    .i_sat(act_sat_val_q),
    .in_px(px_corr),
    .out_px(px_sat)
  );

  assign o_gamma_valid = px_sat.valid;
  assign {o_gamma_b, o_gamma_g, o_gamma_r} = px_sat.ch;
  assign px_gam.valid = i_gamma_valid;
  assign px_gam.ch = {i_gamma_b, i_gamma_g, i_gamma_r};

  // conversion after gamma, fixed coefficients, no enable but the format, the pipe enable and a non-polarized build
  pct_matrix #(.PW(PIX_W), .CW(COEF_W)) u_rgb_to_luma_chroma (
    .i_sys_clk(i_sys_clk),
    .i_rstn(i_rstn),
    .i_apply(act_yuv_q),
    .i_coef(YUV_COEFS),
    .in_px(px_gam),
    .out_px(px_out)
  );

  assign o_pix_valid = px_out.valid;
  assign {o_pix_c2, o_pix_c1, o_pix_c0} = px_out.ch;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rstn);

  sequence s_bypass_in;
    i_pix_valid && !i_frame_sync && !act_rgb_on_q && !act_sat_q ##1 !i_frame_sync [*3];
  endsequence

  sequence s_illum_write;
    i_wr && (i_addr == REG_ILLUM) && xf_ok_w && (i_wdata[2:0] != 3'h7);
  endsequence

  property p_front_latency;
    i_pix_valid |-> ##4 o_gamma_valid;
  endproperty
  a_front_latency: assert property (p_front_latency) else $error("front latency wrong");

  property p_back_latency;
    !i_gamma_valid |-> ##2 !o_pix_valid;
  endproperty
  a_back_latency: assert property (p_back_latency) else $error("back valid wrong");

  property p_rgb_bypass;
    s_bypass_in |=> {o_gamma_b, o_gamma_g, o_gamma_r} == $past({i_pix_b, i_pix_g, i_pix_r}, 4);
  endproperty
  a_rgb_bypass: assert property (p_rgb_bypass) else $error("bypass altered pixel");

  property p_frame_hold;
    !i_frame_sync |=> $stable(act_rgb_q) && $stable(act_yuv_q) && $stable(act_sat_q);
  endproperty
  a_frame_hold: assert property (p_frame_hold) else $error("setting moved mid-frame");

  property p_custom_load;
    i_frame_sync && custom_w |=> act_rgb_q == $past(cust_q);
  endproperty
  a_custom_load: assert property (p_custom_load) else $error("custom bank not loaded");

  property p_preset_load;
    i_frame_sync && !custom_w |=> act_rgb_q == PRESET_COEFS[$past(illum_q)];
  endproperty
  a_preset_load: assert property (p_preset_load) else $error("preset not loaded");

  property p_yuv_follows_fmt;
    i_frame_sync |=> act_yuv_q == $past(xf_ok_w && ctrl_q[CTRL_YUV_FMT_BIT]);
  endproperty
  a_yuv_follows_fmt: assert property (p_yuv_follows_fmt) else $error("yuv not format driven");

  property p_gated_read;
    i_rd && !xf_ok_w && (i_addr != REG_CTRL) && (i_addr != REG_STATUS) |=> o_rdata == '0;
  endproperty
  a_gated_read: assert property (p_gated_read) else $error("read while pipe off");

  property p_yuv_on_ro;
    i_wr && (i_addr == REG_INST_ON) && !sel_rgb_w |=> $stable(rgb_on_q);
  endproperty
  a_yuv_on_ro: assert property (p_yuv_on_ro) else $error("on flag written for yuv");

  property p_wb_preset;
    s_illum_write |=> o_wb_red == WB_RED_TAB[$past(i_wdata[2:0])];
  endproperty
  a_wb_preset: assert property (p_wb_preset) else $error("balance not loaded");

  property p_coef_readback;
    i_rd && xf_ok_w && (i_addr == REG_COEF_VAL) && !sel_rgb_w && (coef_idx_q == 4'h0)
      |=> o_rdata == DATA_W'(YUV_COEFS[0]);
  endproperty
  a_coef_readback: assert property (p_coef_readback) else $error("in-use value not read");
endmodule

// [hdl/pct_pkg.sv]
package pct_pkg;
  // ---------------------------------------------------------------
  // widths and fixed-point format
  // ---------------------------------------------------------------
  localparam int PIX_W = 10;
  localparam int COEF_W = 16;
  localparam int COEF_FRAC = 12;
  localparam int N_COEF = 12;
  localparam int N_PRESET = 7;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int SAT_W = 8;
  localparam int MAT_LAT = 2;
  localparam int SAT_LAT = 2;

  // ---------------------------------------------------------------
  // register offsets and fields
  // ---------------------------------------------------------------
  localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] REG_INST_SEL = 8'h04;
  localparam logic [ADDR_W-1:0] REG_INST_ON = 8'h08;
  localparam logic [ADDR_W-1:0] REG_COEF_SEL = 8'h0c;
  localparam logic [ADDR_W-1:0] REG_COEF_VAL = 8'h10;
  localparam logic [ADDR_W-1:0] REG_ILLUM = 8'h14;
  localparam logic [ADDR_W-1:0] REG_SAT = 8'h18;
  localparam logic [ADDR_W-1:0] REG_WB_RED = 8'h1c;
  localparam logic [ADDR_W-1:0] REG_WB_BLUE = 8'h20;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h24;
  localparam int CTRL_PIPE_EN_BIT = 0;
  localparam int CTRL_YUV_FMT_BIT = 1;
  localparam int CTRL_VIVID_BIT = 2;
  localparam logic [2:0] CTRL_RESET = 3'h1;
  localparam logic RGB_ON_RESET = 1'h1;
  localparam logic [SAT_W-1:0] SAT_RESET = 8'h40;
  localparam int SAT_UNITY_SHIFT = 6;

  // ---------------------------------------------------------------
  // modes
  // ---------------------------------------------------------------
  typedef enum logic {INST_NATIVE_TO_STANDARD_RGB, INST_RGB_TO_LUMA_CHROMA} pct_inst_type;
  typedef enum logic [2:0] {ILLUM_GENERAL, ILLUM_TUNGSTEN, ILLUM_WARM_FLUOR, ILLUM_COOL_FLUOR,
    ILLUM_DAYLIGHT, ILLUM_CLOUDY, ILLUM_SHADE, ILLUM_CUSTOM} pct_illum_type;
  typedef logic [N_COEF-1:0][COEF_W-1:0] pct_coef_type;

  // ---------------------------------------------------------------
  // coefficient sets: gains 0..8 row-major, offsets 9..11 in pixel lsbs
  // ---------------------------------------------------------------
  localparam pct_coef_type IDENT_COEFS = {16'h0000, 16'h0000, 16'h0000,
    16'h1000, 16'h0000, 16'h0000, 16'h0000, 16'h1000, 16'h0000, 16'h0000, 16'h0000, 16'h1000};
  localparam pct_coef_type YUV_COEFS = {16'h0200, 16'h0200, 16'h0000,
    16'hfeb3, 16'hf94d, 16'h0800, 16'h0800, 16'hfab3, 16'hfd4d, 16'h01d3, 16'h0964, 16'h04c9};
  localparam logic [N_PRESET-1:0][COEF_W-1:0] WB_RED_TAB = {16'h1a00, 16'h1800, 16'h1600,
    16'h1400, 16'h1200, 16'h1000, 16'h1300};
  localparam logic [N_PRESET-1:0][COEF_W-1:0] WB_BLUE_TAB = {16'h1000, 16'h1100, 16'h1300,
    16'h1600, 16'h1900, 16'h1c00, 16'h1500};
  localparam logic [7:0] LUMA_R_WT = 8'h4d;
  localparam logic [7:0] LUMA_G_WT = 8'h96;
  localparam logic [7:0] LUMA_B_WT = 8'h1d;

  // coefficient lookup with out-of-range index reading as zero
  function automatic logic [COEF_W-1:0] coef_at(input pct_coef_type v, input logic [3:0] idx);
    coef_at = (idx < 4'(N_COEF)) ? v[idx] : '0;
  endfunction
endpackage

// [hdl/pct_pix_if.sv]
`timescale 1ns/10ps
interface pct_pix_if #(parameter int PW = pct_pkg::PIX_W);
  logic valid;
  logic [2:0][PW-1:0] ch;
  modport src(output valid, output ch);
  modport dst(input valid, input ch);
endinterface

// [hdl/pct_matrix.sv]
`timescale 1ns/10ps
module pct_matrix #(
  parameter int PW = pct_pkg::PIX_W,
  parameter int CW = pct_pkg::COEF_W
) (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  // coefficients and apply
  input wire logic i_apply,
  input wire logic [pct_pkg::N_COEF-1:0][CW-1:0] i_coef,
  // pixel stream
  pct_pix_if.dst in_px,
  pct_pix_if.src out_px
);
  import pct_pkg::*;
  localparam int AW = CW + PW + 4;
  localparam logic signed [AW-1:0] ROUND_HALF = AW'(1) <<< (COEF_FRAC - 1);
  logic signed [AW-1:0] sum_w [3];
  logic signed [AW-1:0] acc_q [3];
  logic [2:0][PW-1:0] raw_q;
  logic [2:0][PW-1:0] clip_w;
  logic [2:0][PW-1:0] res_q;
  logic v1_q;
  logic v2_q;
  logic apply_q;

  // one row per output channel: gains times inputs, plus scaled offset, rounded
  for (genvar r = 0; r < 3; r++) begin : g_row
    wire signed [AW-1:0] shr_w = acc_q[r] >>> COEF_FRAC;
    assign sum_w[r] = AW'($signed(i_coef[3*r])) * AW'($signed({1'b0, in_px.ch[0]}))
      + AW'($signed(i_coef[3*r+1])) * AW'($signed({1'b0, in_px.ch[1]}))
      + AW'($signed(i_coef[3*r+2])) * AW'($signed({1'b0, in_px.ch[2]}))
      + (AW'($signed(i_coef[9+r])) <<< COEF_FRAC) + ROUND_HALF;
    // clamp: negative to zero, overflow to full scale
    assign clip_w[r] = shr_w[AW-1] ? '0 : ((|shr_w[AW-2:PW]) ? '1 : shr_w[PW-1:0]);
  end

  // two stages: accumulate, then round and clamp; bypass keeps same latency
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      v1_q <= 1'b0;
      v2_q <= 1'b0;
      apply_q <= 1'b0;
      raw_q <= '0;
      acc_q <= '{default: '0};
      res_q <= '0;
    end else begin
      v1_q <= in_px.valid;
      apply_q <= i_apply;
      raw_q <= in_px.ch;
      acc_q <= sum_w;
      v2_q <= v1_q;
      res_q <= apply_q ? clip_w : raw_q;
    end
  end

  assign out_px.valid = v2_q;
  assign out_px.ch = res_q;
endmodule

// [hdl/pct_saturate.sv]
`timescale 1ns/10ps
module pct_saturate #(
  parameter int PW = pct_pkg::PIX_W
) (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  // control
  input wire logic i_apply,
  input wire logic [pct_pkg::SAT_W-1:0] i_sat,
  // pixel stream
  pct_pix_if.dst in_px,
  pct_pix_if.src out_px
);
  import pct_pkg::*;
  localparam int SW = PW + SAT_W + 4;
  logic [PW+9:0] luma_sum_w;
  logic [PW-1:0] luma_q;
  logic [2:0][PW-1:0] raw_q;
  logic [2:0][PW-1:0] vivid_w;
  logic [2:0][PW-1:0] res_q;
  logic [SAT_W-1:0] sat_q;
  logic v1_q;
  logic v2_q;
  logic apply_q;

  // cheap luma estimate; weights sum to 256
  assign luma_sum_w = (PW+10)'(in_px.ch[0]) * (PW+10)'(LUMA_R_WT)
    + (PW+10)'(in_px.ch[1]) * (PW+10)'(LUMA_G_WT) + (PW+10)'(in_px.ch[2]) * (PW+10)'(LUMA_B_WT);

  // push each channel away from luma by the saturation factor
  for (genvar c = 0; c < 3; c++) begin : g_chan
    wire signed [SW-1:0] diff_w = SW'($signed({1'b0, raw_q[c]})) - SW'($signed({1'b0, luma_q}));
    wire signed [SW-1:0] scl_w = (diff_w * SW'($signed({1'b0, sat_q}))) >>> SAT_UNITY_SHIFT;
    wire signed [SW-1:0] val_w = scl_w + SW'($signed({1'b0, luma_q}));
    assign vivid_w[c] = val_w[SW-1] ? '0 : ((|val_w[SW-2:PW]) ? '1 : val_w[PW-1:0]);
  end

  // stage one holds luma, stage two the adjusted colour
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      v1_q <= 1'b0;
      v2_q <= 1'b0;
      apply_q <= 1'b0;
      sat_q <= '0;
      luma_q <= '0;
      raw_q <= '0;
      res_q <= '0;
    end else begin
      v1_q <= in_px.valid;
      apply_q <= i_apply;
      sat_q <= i_sat;
      luma_q <= luma_sum_w[PW+7:8];
      raw_q <= in_px.ch;
      v2_q <= v1_q;
      res_q <= apply_q ? vivid_w : raw_q;
    end
  end

  assign out_px.valid = v2_q;
  assign out_px.ch = res_q;
endmodule

// [tb/pct_gamma_model.sv]
`timescale 1ns/10ps
// stand-in gamma stage: unity curve behind one register
module pct_gamma_model (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  // corrected rgb in
  input wire logic i_valid,
  input wire logic [29:0] i_rgb,
  // gamma rgb out
  output logic o_valid,
  output logic [29:0] o_rgb
);
  // idle cycles show inverted data so a stale word never passes for a pixel
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_valid <= 1'b0;
      o_rgb <= '0;
    end else begin
      o_valid <= i_valid;
      o_rgb <= i_valid ? i_rgb : ~o_rgb;
    end
  end
endmodule

// [tb/test_pct_color_xform.sv]
`timescale 1ns/10ps
module test_pct_color_xform;
  import pct_pkg::*;
  logic i_sys_clk, i_rstn, i_wr, i_rd, i_frame_sync, i_pix_valid, gv, o_gamma_valid, o_pix_valid;
  logic [ADDR_W-1:0] i_addr;
  logic [DATA_W-1:0] i_wdata, o_rdata;
  logic [29:0] pin, gam;
  logic [PIX_W-1:0] o_gamma_r, o_gamma_g, o_gamma_b, o_pix_c0, o_pix_c1, o_pix_c2;
  logic [COEF_W-1:0] o_wb_red, o_wb_blue;
  int bad_count = 0;
  int tests_run = 0;

  // ---------------------------------------------------------------
  // design and far-side gamma loop
  // ---------------------------------------------------------------
  pct_color_xform u_dut (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_frame_sync(i_frame_sync), .i_pix_valid(i_pix_valid),
    .i_pix_r(pin[29:20]), .i_pix_g(pin[19:10]), .i_pix_b(pin[9:0]), .o_gamma_valid(o_gamma_valid),
    .o_gamma_r(o_gamma_r), .o_gamma_g(o_gamma_g), .o_gamma_b(o_gamma_b), .i_gamma_valid(gv),
    .i_gamma_r(gam[29:20]), .i_gamma_g(gam[19:10]), .i_gamma_b(gam[9:0]), .o_pix_valid(o_pix_valid),
    .o_pix_c0(o_pix_c0), .o_pix_c1(o_pix_c1), .o_pix_c2(o_pix_c2), .o_wb_red(o_wb_red), .o_wb_blue(o_wb_blue));
  pct_gamma_model u_gamma (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_valid(o_gamma_valid),
    .i_rgb({o_gamma_r, o_gamma_g, o_gamma_b}), .o_valid(gv), .o_rgb(gam));

  // 100 ns clock
  initial begin
    i_sys_clk = 1'b0;
    forever #50 i_sys_clk = ~i_sys_clk;
  end

  // ---------------------------------------------------------------
  // access tasks
  // ---------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge i_sys_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_sys_clk);
    i_wr <= 1'b0;
    // step off the edge so callers see the registers that the write just loaded
    #1;
  endtask
  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
    @(posedge i_sys_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_sys_clk);
    i_rd <= 1'b0;
    #1 chk("rdata", exp, o_rdata);
  endtask
  task automatic sync();
    @(posedge i_sys_clk);
    i_frame_sync <= 1'b1;
    @(posedge i_sys_clk);
    i_frame_sync <= 1'b0;
  endtask
  // one pixel; gamma side checked at +4, formatter side 2 after the loop
  task automatic px(input logic [29:0] pi, input logic [29:0] ge, input logic [29:0] fe);
    @(posedge i_sys_clk);
    i_pix_valid <= 1'b1;
    pin <= pi;
    @(posedge i_sys_clk);
    i_pix_valid <= 1'b0;
    pin <= ~pi;
    repeat (3) @(posedge i_sys_clk);
    #1 chk("gamma", {1'b0, o_gamma_valid, o_gamma_r, o_gamma_g, o_gamma_b}, {2'b01, ge});
    repeat (3) @(posedge i_sys_clk);
    #1 chk("final", {1'b0, o_pix_valid, o_pix_c0, o_pix_c1, o_pix_c2}, {2'b01, fe});
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // watchdog: the sequence needs well under a thousand cycles
  initial begin
    #1_000_000;
    bad_count++;
    finish_test();
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    {i_rstn, i_wr, i_rd, i_frame_sync, i_pix_valid, i_addr, i_wdata, pin} = '0;
    repeat (5) @(posedge i_sys_clk);
    i_rstn <= 1'b1;
    rd(REG_CTRL, 32'(CTRL_RESET));
    rd(REG_INST_ON, 32'h1);
    rd(REG_SAT, 32'(SAT_RESET));
    rd(8'h28, 32'h0);
    chk("wb_red", 32'(WB_RED_TAB[0]), 32'(o_wb_red));
    px({10'd100, 10'd200, 10'd300}, {10'd100, 10'd200, 10'd300}, {10'd100, 10'd200, 10'd300});
    wr(REG_ILLUM, 32'h3);
    chk("wb_red", 32'(WB_RED_TAB[3]), 32'(o_wb_red));
    chk("wb_blue", 32'(WB_BLUE_TAB[3]), 32'(o_wb_blue));
    // custom gain 2.0 and offset 5 on channel 0, seen only after the boundary
    wr(REG_ILLUM, 32'h7);
    wr(REG_COEF_SEL, 32'h0);
    wr(REG_COEF_VAL, 32'h2000);
    wr(REG_COEF_SEL, 32'h9);
    wr(REG_COEF_VAL, 32'h5);
    rd(REG_COEF_VAL, 32'h0);
    sync();
    rd(REG_COEF_VAL, 32'h5);
    px({10'd100, 10'd200, 10'd300}, {10'd205, 10'd200, 10'd300}, {10'd205, 10'd200, 10'd300});
    px({10'd600, 10'd7, 10'd9}, {10'd1023, 10'd7, 10'd9}, {10'd1023, 10'd7, 10'd9});
    wr(REG_INST_ON, 32'h0);
    sync();
    px({10'd100, 10'd200, 10'd300}, {10'd100, 10'd200, 10'd300}, {10'd100, 10'd200, 10'd300});
    // yuv output format; instance on flag is read-only there
    wr(REG_CTRL, 32'h3);
    sync();
    wr(REG_INST_SEL, 32'h1);
    rd(REG_INST_ON, 32'h1);
    wr(REG_INST_ON, 32'h0);
    rd(REG_INST_ON, 32'h1);
    wr(REG_COEF_SEL, 32'h0);
    rd(REG_COEF_VAL, 32'(YUV_COEFS[0]));
    px({10'd512, 10'd0, 10'd0}, {10'd512, 10'd0, 10'd0}, {10'd153, 10'd426, 10'd768});
    // vividness at twice unity: luma 154, red pushed to 870, others clamp to 0
    wr(REG_CTRL, 32'h5);
    wr(REG_SAT, 32'h80);
    sync();
    px({10'd512, 10'd0, 10'd0}, {10'd870, 10'd0, 10'd0}, {10'd870, 10'd0, 10'd0});
    wr(REG_CTRL, 32'h0);
    rd(REG_ILLUM, 32'h0);
    wr(REG_CTRL, 32'h1);
    rd(REG_ILLUM, 32'h7);
    // back to a calibrated preset: the custom gain must give way at the boundary
    wr(REG_INST_SEL, 32'h0);
    wr(REG_ILLUM, 32'h3);
    sync();
    rd(REG_COEF_VAL, 32'(IDENT_COEFS[0]));
    finish_test();
  end
endmodule
